// File: inc/ladder_pkg.sv
// Shared opcodes, carriers, timing figures and BCD helpers for the ladder datapath
package ladder_pkg;

   // Function codes, decimal 12..46 held in hexadecimal
   localparam logic [7:0] OP_COUNTER = 8'h0C;
   localparam logic [7:0] OP_RISE = 8'h0D;
   localparam logic [7:0] OP_FALL = 8'h0E;
   localparam logic [7:0] OP_FAST_TIMER = 8'h0F;
   localparam logic [7:0] OP_WORD_SHIFT = 8'h10;
   localparam logic [7:0] OP_COMPARE = 8'h14;
   localparam logic [7:0] OP_COPY = 8'h15;
   localparam logic [7:0] OP_COPY_INV = 8'h16;
   localparam logic [7:0] OP_BCD_TO_BIN = 8'h17;
   localparam logic [7:0] OP_BIN_TO_BCD = 8'h18;
   localparam logic [7:0] OP_SHIFT_LEFT = 8'h19;
   localparam logic [7:0] OP_SHIFT_RIGHT = 8'h1A;
   localparam logic [7:0] OP_ROT_LEFT = 8'h1B;
   localparam logic [7:0] OP_ROT_RIGHT = 8'h1C;
   localparam logic [7:0] OP_INVERT = 8'h1D;
   localparam logic [7:0] OP_BCD_ADD = 8'h1E;
   localparam logic [7:0] OP_BCD_SUB = 8'h1F;
   localparam logic [7:0] OP_BCD_MUL = 8'h20;
   localparam logic [7:0] OP_BCD_DIV = 8'h21;
   localparam logic [7:0] OP_AND = 8'h22;
   localparam logic [7:0] OP_OR = 8'h23;
   localparam logic [7:0] OP_XOR = 8'h24;
   localparam logic [7:0] OP_XNOR = 8'h25;
   localparam logic [7:0] OP_BCD_INC = 8'h26;
   localparam logic [7:0] OP_BCD_DEC = 8'h27;
   localparam logic [7:0] OP_CARRY_SET = 8'h28;
   localparam logic [7:0] OP_CARRY_CLR = 8'h29;
   localparam logic [7:0] OP_MESSAGE = 8'h2E;

   // Sizes
   localparam int SLOT_W = 4;
   localparam int SLOTS = 16;
   localparam int MSG_CHARS = 16;
   localparam logic [4:0] MSG_LAST = 5'h0F;

   // Reset values and BCD limits
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [31:0] BCD_TOP = 32'h0000_270F;
   localparam logic [31:0] BCD_MOD = 32'h0000_2710;

   // Fast timer time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int FAST_BASE_MS = 10;
   localparam int FAST_BASE_CYCLES = FAST_BASE_MS * 1000000 / CLK_PERIOD_NS;

   typedef struct packed {
      logic [7:0] code;
      logic edge_mode;
      logic cond;
      logic up;
      logic down;
      logic [SLOT_W-1:0] slot;
      logic [15:0] a;
      logic [15:0] b;
   } op_req_t;

   typedef struct packed {
      logic cy;
      logic above;
      logic match;
      logic below;
      logic err;
   } flags_t;

   function automatic logic bcd_ok(input logic [15:0] v);
      bcd_ok = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) && (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
   endfunction

   function automatic logic [31:0] bcd2bin(input logic [31:0] v);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 7; i >= 0; i--)
      begin
         r = r * 32'd10 + {28'h0, v[i*4 +: 4]};
      end
      return r;
   endfunction

   // Double dabble; callers keep the value within eight digits
   function automatic logic [31:0] bin2bcd(input logic [31:0] v);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 31; i >= 0; i--)
      begin
         for (int d = 0; d < 8; d++)
         begin
            if (r[d*4 +: 4] > 4'h4)
            begin
               r[d*4 +: 4] = r[d*4 +: 4] + 4'h3;
            end
         end
         r = {r[30:0], v[i]};
      end
      return r;
   endfunction

   // One BCD step with wrap between 0000 and 9999
   function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic up);
      logic [31:0] b;
      logic [31:0] r;
      b = bcd2bin({16'h0, v});
      if (up)
      begin
         b = (b == BCD_TOP) ? 32'h0 : b + 32'h1;
      end
      else
      begin
         b = (b == 32'h0) ? BCD_TOP : b - 32'h1;
      end
      r = bin2bcd(b);
      return r[15:0];
   endfunction

endpackage

// File: rtl/fast_timer.sv
// Fast time base on-delay timer with a BCD present value
`timescale 1ns/1ns
module fast_timer #(
   parameter int TICK_CYCLES = ladder_pkg::FAST_BASE_CYCLES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Evaluation from the datapath
   input wire logic eval,
   input wire logic cond,
   input wire logic [15:0] set_bcd,
   // State
   output logic [15:0] pv,
   output logic done
);
   logic [31:0] tick_cnt_r;
   logic run_r;
   logic [15:0] pv_r;
   wire tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

   // Condition off reloads; on keeps counting between scans
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_cnt_r <= 32'h0;
         run_r <= 1'b0;
         pv_r <= ladder_pkg::WORD_RST;
      end
      else
      begin
         tick_cnt_r <= (tick || !run_r) ? 32'h0 : tick_cnt_r + 32'h1;
         if (eval && !cond)
         begin
            run_r <= 1'b0;
            pv_r <= set_bcd;
         end
         else if (eval && !run_r)
         begin
            run_r <= 1'b1;
         end
         else if (run_r && tick && pv_r != 16'h0000)
         begin
            pv_r <= ladder_pkg::bcd_step(pv_r, 1'b0);
         end
      end
   end

   assign pv = pv_r;
   assign done = run_r && (pv_r == 16'h0000);

endmodule

// File: rtl/ladder_instruction_datapath.sv
// Ladder instruction execution datapath, function codes 12 to 46
`timescale 1ns/1ns
module ladder_instruction_datapath #(
   parameter int MEM_WORDS = 16,
   parameter int TICK_CYCLES = ladder_pkg::FAST_BASE_CYCLES
)(
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Instruction request
   input wire logic OP_VALID,
   input wire ladder_pkg::op_req_t OP_REQ,
   output logic OP_READY,
   output logic OP_DONE,
   // Results and flags
   output logic [15:0] RES_LO,
   output logic [15:0] RES_HI,
   output ladder_pkg::flags_t FLAGS,
   output logic [ladder_pkg::SLOTS-1:0] PULSE_BITS,
   output logic [15:0] COUNT_PV,
   output logic [15:0] TIMER_PV,
   output logic TIMER_UP,
   // Word memory port
   input wire logic MEM_WE,
   input wire logic [$clog2(MEM_WORDS)-1:0] MEM_ADDR,
   input wire logic [15:0] MEM_WDATA,
   output logic [15:0] MEM_RDATA,
   // Display characters
   output logic MSG_VALID,
   output logic [7:0] MSG_CHAR
);
   localparam int AW = $clog2(MEM_WORDS);

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_MSG} state_t;

   state_t state_r;
   logic [15:0] mem [MEM_WORDS];
   logic [AW-1:0] idx_r;
   logic [AW-1:0] start_r;
   logic [4:0] chr_r;
   logic done_r;
   logic msg_valid_r;
   logic [7:0] msg_char_r;
   logic [15:0] rdata_r;
   logic [15:0] res_lo_r;
   logic [15:0] res_hi_r;
   ladder_pkg::flags_t flags_r;
   logic [ladder_pkg::SLOTS-1:0] prev_cond_r;
   logic [ladder_pkg::SLOTS-1:0] prev_up_r;
   logic [ladder_pkg::SLOTS-1:0] prev_down_r;
   logic [ladder_pkg::SLOTS-1:0] pulse_r;
   logic [15:0] cnt_pv_r [ladder_pkg::SLOTS];
   logic [15:0] count_out_r;
   logic [ladder_pkg::SLOT_W-1:0] last_slot_r;

   // Request decode
   wire [7:0] code = OP_REQ.code;
   wire [ladder_pkg::SLOT_W-1:0] slot = OP_REQ.slot;
   wire [15:0] a = OP_REQ.a;
   wire [15:0] b = OP_REQ.b;
   wire take = OP_VALID && OP_READY;
   wire rose = OP_REQ.cond && !prev_cond_r[slot];
   wire fell = !OP_REQ.cond && prev_cond_r[slot];
   wire fire = take && (OP_REQ.edge_mode ? rose : OP_REQ.cond);
   wire a_ok = ladder_pkg::bcd_ok(a);
   wire b_ok = ladder_pkg::bcd_ok(b);
   wire [31:0] a_bin = ladder_pkg::bcd2bin({16'h0, a});
   wire [31:0] b_bin = ladder_pkg::bcd2bin({16'h0, b});
   wire up_rise = OP_REQ.up && !prev_up_r[slot];
   wire down_rise = OP_REQ.down && !prev_down_r[slot];
   wire [AW-1:0] range_lo = a[AW-1:0];
   wire [AW-1:0] range_hi = b[AW-1:0];
   wire shift_go = fire && code == ladder_pkg::OP_WORD_SHIFT && range_hi >= range_lo;
   wire msg_go = fire && code == ladder_pkg::OP_MESSAGE;
   wire shift_end = state_r == ST_SHIFT && idx_r == start_r;
   wire msg_end = state_r == ST_MSG && chr_r == ladder_pkg::MSG_LAST;
   wire [15:0] msg_word = mem[start_r];

   logic [15:0] lo_nxt;
   logic [15:0] hi_nxt;
   ladder_pkg::flags_t flags_nxt;

   // Single-scan word arithmetic; errors leave the result words untouched
   always_comb
   begin
      logic [31:0] s;
      logic [31:0] t;
      logic [31:0] u;
      s = 32'h0;
      t = 32'h0;
      u = 32'h0;
      lo_nxt = res_lo_r;
      hi_nxt = res_hi_r;
      flags_nxt = flags_r;
      flags_nxt.err = 1'b0;
      case (code)
         ladder_pkg::OP_COMPARE:
         begin
            flags_nxt.above = a > b;
            flags_nxt.match = a == b;
            flags_nxt.below = a < b;
         end
         ladder_pkg::OP_COPY: lo_nxt = a;
         ladder_pkg::OP_COPY_INV: lo_nxt = ~a;
         ladder_pkg::OP_INVERT: lo_nxt = ~a;
         ladder_pkg::OP_BCD_TO_BIN:
         begin
            if (a_ok) lo_nxt = a_bin[15:0];
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_BIN_TO_BCD:
         begin
            t = ladder_pkg::bin2bcd({16'h0, a});
            if ({16'h0, a} <= ladder_pkg::BCD_TOP) lo_nxt = t[15:0];
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_SHIFT_LEFT:
         begin
            lo_nxt = {a[14:0], 1'b0};
            flags_nxt.cy = a[15];
         end
         ladder_pkg::OP_SHIFT_RIGHT:
         begin
            lo_nxt = {1'b0, a[15:1]};
            flags_nxt.cy = a[0];
         end
         ladder_pkg::OP_ROT_LEFT:
         begin
            lo_nxt = {a[14:0], flags_r.cy};
            flags_nxt.cy = a[15];
         end
         ladder_pkg::OP_ROT_RIGHT:
         begin
            lo_nxt = {flags_r.cy, a[15:1]};
            flags_nxt.cy = a[0];
         end
         ladder_pkg::OP_BCD_ADD:
         begin
            if (a_ok && b_ok)
            begin
               s = a_bin + b_bin + {31'h0, flags_r.cy};
               flags_nxt.cy = s >= ladder_pkg::BCD_MOD;
               if (s >= ladder_pkg::BCD_MOD) s = s - ladder_pkg::BCD_MOD;
               t = ladder_pkg::bin2bcd(s);
               lo_nxt = t[15:0];
            end
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_BCD_SUB:
         begin
            if (a_ok && b_ok)
            begin
               u = b_bin + {31'h0, flags_r.cy};
               flags_nxt.cy = a_bin < u;
               s = (a_bin < u) ? a_bin + ladder_pkg::BCD_MOD - u : a_bin - u;
               t = ladder_pkg::bin2bcd(s);
               lo_nxt = t[15:0];
            end
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_BCD_MUL:
         begin
            if (a_ok && b_ok)
            begin
               t = ladder_pkg::bin2bcd(a_bin * b_bin);
               lo_nxt = t[15:0];
               hi_nxt = t[31:16];
            end
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_BCD_DIV:
         begin
            // A zero divisor is treated as a digit fault
            if (a_ok && b_ok && b_bin != 32'h0)
            begin
               t = ladder_pkg::bin2bcd(a_bin / b_bin);
               u = ladder_pkg::bin2bcd(a_bin % b_bin);
               lo_nxt = t[15:0];
               hi_nxt = u[15:0];
            end
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_AND: lo_nxt = a & b;
         ladder_pkg::OP_OR: lo_nxt = a | b;
         ladder_pkg::OP_XOR: lo_nxt = a ^ b;
         ladder_pkg::OP_XNOR: lo_nxt = ~(a ^ b);
         ladder_pkg::OP_BCD_INC:
         begin
            if (a_ok) lo_nxt = ladder_pkg::bcd_step(a, 1'b1);
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_BCD_DEC:
         begin
            if (a_ok) lo_nxt = ladder_pkg::bcd_step(a, 1'b0);
            else flags_nxt.err = 1'b1;
         end
         ladder_pkg::OP_CARRY_SET: flags_nxt.cy = 1'b1;
         ladder_pkg::OP_CARRY_CLR: flags_nxt.cy = 1'b0;
         ladder_pkg::OP_WORD_SHIFT: flags_nxt.err = range_hi < range_lo;
         default: ;
      endcase
   end

   // Result words and flags
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         res_lo_r <= ladder_pkg::WORD_RST;
         res_hi_r <= ladder_pkg::WORD_RST;
         flags_r <= '0;
      end
      else if (fire)
      begin
         res_lo_r <= lo_nxt;
         res_hi_r <= hi_nxt;
         flags_r <= flags_nxt;
      end
   end

   // Per-slot edge memory, pulses and counters; slots are visited once per scan
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         prev_cond_r <= '0;
         prev_up_r <= '0;
         prev_down_r <= '0;
         pulse_r <= '0;
         count_out_r <= ladder_pkg::WORD_RST;
         last_slot_r <= '0;
         for (int i = 0; i < ladder_pkg::SLOTS; i++)
         begin
            cnt_pv_r[i] <= ladder_pkg::WORD_RST;
         end
      end
      else if (take)
      begin
         prev_cond_r[slot] <= OP_REQ.cond;
         last_slot_r <= slot;
         if (code == ladder_pkg::OP_RISE) pulse_r[slot] <= rose;
         if (code == ladder_pkg::OP_FALL) pulse_r[slot] <= fell;
         if (code == ladder_pkg::OP_COUNTER)
         begin
            prev_up_r[slot] <= OP_REQ.up;
            prev_down_r[slot] <= OP_REQ.down;
            // Condition acts as the counter's reset input
            if (OP_REQ.cond)
            begin
               cnt_pv_r[slot] <= ladder_pkg::WORD_RST;
               count_out_r <= ladder_pkg::WORD_RST;
            end
            else if (up_rise != down_rise)
            begin
               cnt_pv_r[slot] <= ladder_pkg::bcd_step(cnt_pv_r[slot], up_rise);
               count_out_r <= ladder_pkg::bcd_step(cnt_pv_r[slot], up_rise);
            end
            else
            begin
               count_out_r <= cnt_pv_r[slot];
            end
         end
      end
   end

   // Word memory; host writes are only taken while idle
   always_ff @(posedge CLK)
   begin
      if (state_r == ST_SHIFT)
      begin
         mem[idx_r] <= shift_end ? 16'h0000 : mem[AW'(idx_r - 1'b1)];
      end
      else if (state_r == ST_IDLE && MEM_WE)
      begin
         mem[MEM_ADDR] <= MEM_WDATA;
      end
   end

   // Multi-cycle sequencing for word shift and message
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_r <= ST_IDLE;
         idx_r <= '0;
         start_r <= '0;
         chr_r <= 5'h00;
         done_r <= 1'b0;
         msg_valid_r <= 1'b0;
         msg_char_r <= 8'h00;
         rdata_r <= ladder_pkg::WORD_RST;
      end
      else
      begin
         rdata_r <= mem[MEM_ADDR];
         msg_valid_r <= state_r == ST_MSG;
         done_r <= (take && !shift_go && !msg_go) || shift_end || msg_end;
         case (state_r)
            ST_IDLE:
            begin
               chr_r <= 5'h00;
               if (shift_go)
               begin
                  state_r <= ST_SHIFT;
                  start_r <= range_lo;
                  idx_r <= range_hi;
               end
               else if (msg_go)
               begin
                  state_r <= ST_MSG;
                  start_r <= a[AW-1:0];
               end
            end
            ST_SHIFT:
            begin
               idx_r <= AW'(idx_r - 1'b1);
               if (shift_end) state_r <= ST_IDLE;
            end
            ST_MSG:
            begin
               // High byte first, two characters per word
               msg_char_r <= chr_r[0] ? msg_word[7:0] : msg_word[15:8];
               chr_r <= chr_r + 5'h01;
               if (chr_r[0]) start_r <= AW'(start_r + 1'b1);
               if (msg_end) state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   fast_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk(CLK),
      .nrst(NRST),
      .eval(take && code == ladder_pkg::OP_FAST_TIMER),
      .cond(OP_REQ.cond),
      .set_bcd(a),
      .pv(TIMER_PV),
      .done(TIMER_UP)
   );

   assign OP_READY = state_r == ST_IDLE;
   assign OP_DONE = done_r;
   assign RES_LO = res_lo_r;
   assign RES_HI = res_hi_r;
   assign FLAGS = flags_r;
   assign PULSE_BITS = pulse_r;
   assign COUNT_PV = count_out_r;
   assign MEM_RDATA = rdata_r;
   assign MSG_VALID = msg_valid_r;
   assign MSG_CHAR = msg_char_r;

   sequence msg_start;
      fire && code == ladder_pkg::OP_MESSAGE;
   endsequence

   sequence msg_burst;
      MSG_VALID [*8] ##1 MSG_VALID [*8];
   endsequence

   a_rise_pulse: assert property (@(posedge CLK) disable iff (!NRST)
      take && code == ladder_pkg::OP_RISE |=> PULSE_BITS[last_slot_r] == $past(rose))
      else $error("rise pulse wrong");
   a_fall_pulse: assert property (@(posedge CLK) disable iff (!NRST)
      take && code == ladder_pkg::OP_FALL |=> PULSE_BITS[last_slot_r] == $past(fell))
      else $error("fall pulse wrong");
   a_copy_word: assert property (@(posedge CLK) disable iff (!NRST)
      fire && code == ladder_pkg::OP_COPY_INV |=> RES_LO == ~$past(a) && OP_DONE)
      else $error("inverted copy wrong");
   a_compare_flags: assert property (@(posedge CLK) disable iff (!NRST)
      fire && code == ladder_pkg::OP_COMPARE |=> FLAGS.above == ($past(a) > $past(b))
      && FLAGS.below == ($past(a) < $past(b)) && FLAGS.match == ($past(a) == $past(b)))
      else $error("compare flags wrong");
   a_carry_force: assert property (@(posedge CLK) disable iff (!NRST)
      fire && code == ladder_pkg::OP_CARRY_SET ##1 fire && code == ladder_pkg::OP_CARRY_CLR
      |=> !FLAGS.cy && $past(FLAGS.cy))
      else $error("carry set or clear wrong");
   a_edge_only: assert property (@(posedge CLK) disable iff (!NRST)
      take && OP_REQ.edge_mode && !rose && code == ladder_pkg::OP_COPY |=> $stable(RES_LO))
      else $error("edge variant ran without rise");
   a_bcd_guard: assert property (@(posedge CLK) disable iff (!NRST)
      fire && code == ladder_pkg::OP_BCD_ADD && !a_ok |=> FLAGS.err && $stable(RES_LO))
      else $error("bad digit not caught");
   a_shift_bound: assert property (@(posedge CLK) disable iff (!NRST)
      shift_go |=> !OP_READY ##[0:16] OP_DONE)
      else $error("word shift did not finish");
   a_msg_length: assert property (@(posedge CLK) disable iff (!NRST)
      msg_start |-> ##2 msg_burst ##0 OP_DONE ##1 !MSG_VALID)
      else $error("message not sixteen characters");
   a_swap_carry: assert property (@(posedge CLK) disable iff (!NRST)
      fire && code == ladder_pkg::OP_ROT_LEFT |=> RES_LO[0] == $past(FLAGS.cy) && FLAGS.cy == $past(a[15]))
      else $error("rotate through carry wrong");

endmodule

// File: dv/testbench.sv
// Self-checking bench for the ladder instruction datapath
`timescale 1ns/1ns
module testbench;
   logic CLK, NRST, OP_VALID, OP_READY, OP_DONE, TIMER_UP, MEM_WE, MSG_VALID;
   ladder_pkg::op_req_t OP_REQ;
   ladder_pkg::flags_t FLAGS;
   logic [15:0] RES_LO, RES_HI, PULSE_BITS, COUNT_PV, TIMER_PV, MEM_WDATA, MEM_RDATA;
   logic [3:0] MEM_ADDR;
   logic [7:0] MSG_CHAR;
   int fails, n_tests, k;

   // Short tick keeps the timer scenario to about sixteen cycles
   ladder_instruction_datapath #(.MEM_WORDS(16), .TICK_CYCLES(4)) ladder_instruction_datapath_inst (
      .CLK(CLK), .NRST(NRST), .OP_VALID(OP_VALID), .OP_REQ(OP_REQ), .OP_READY(OP_READY), .OP_DONE(OP_DONE),
      .RES_LO(RES_LO), .RES_HI(RES_HI), .FLAGS(FLAGS), .PULSE_BITS(PULSE_BITS), .COUNT_PV(COUNT_PV),
      .TIMER_PV(TIMER_PV), .TIMER_UP(TIMER_UP), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
      .MEM_RDATA(MEM_RDATA), .MSG_VALID(MSG_VALID), .MSG_CHAR(MSG_CHAR));

   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chb(input string w, input logic e, input logic g);
      chk(w, {15'h0000, e}, {15'h0000, g});
   endtask

   // Characters are judged on the cycle they appear, since each stands one cycle only.
   // Done also stands one cycle, so it is first looked at just after the take edge.
   task automatic run(input logic [7:0] c, input logic e, cd, u, d, input logic [3:0] s, input logic [15:0] a, b);
      int n;
      @(posedge CLK);
      OP_VALID <= 1'b1;
      OP_REQ <= '{c, e, cd, u, d, s, a, b};
      @(posedge CLK);
      OP_VALID <= 1'b0;
      #1;
      for (n = 0; n < 40 && OP_DONE !== 1'b1; n++)
      begin
         @(posedge CLK);
         #1;
         chb("ready", OP_DONE, OP_READY);
         if (MSG_VALID === 1'b1)
         begin
            chk("char", {8'h00, 8'(8'h41 + k)}, {8'h00, MSG_CHAR});
            k++;
         end
      end
      chb("done", 1'b1, OP_DONE);
   endtask

   task automatic go(input logic [7:0] c, input logic [15:0] a, b);
      run(c, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, b);
   endtask

   task automatic opr(input logic [7:0] c, input logic [15:0] a, b, er);
      go(c, a, b);
      chk("result", er, RES_LO);
   endtask

   task automatic opc(input logic [7:0] c, input logic [15:0] a, b, er, input logic ec);
      opr(c, a, b, er);
      chb("carry", ec, FLAGS.cy);
   endtask

   task automatic cyop(input logic [7:0] c, input logic ec);
      go(c, 16'h0000, 16'h0000);
      chb("carry", ec, FLAGS.cy);
   endtask

   task automatic ed(input logic cd, input logic [15:0] a, er);
      run(ladder_pkg::OP_COPY, 1'b1, cd, 1'b0, 1'b0, 4'h3, a, 16'h0000);
      chk("edge", er, RES_LO);
   endtask

   task automatic pl(input logic [7:0] c, input logic [3:0] s, input logic cd, e);
      run(c, 1'b0, cd, 1'b0, 1'b0, s, 16'h0000, 16'h0000);
      chb("pulse", e, PULSE_BITS[s]);
   endtask

   task automatic ct(input logic cd, u, d, input logic [15:0] e);
      run(ladder_pkg::OP_COUNTER, 1'b0, cd, u, d, 4'h5, 16'h0000, 16'h0000);
      chk("count", e, COUNT_PV);
   endtask

   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge CLK);
      MEM_WE <= 1'b1;
      MEM_ADDR <= ad;
      MEM_WDATA <= d;
      @(posedge CLK);
      MEM_WE <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] ad, input logic [15:0] e);
      @(posedge CLK);
      MEM_ADDR <= ad;
      repeat (2) @(posedge CLK);
      #1;
      chk("word", e, MEM_RDATA);
   endtask

   task automatic t_logic();
      opr(ladder_pkg::OP_COPY, 16'hF0CC, 16'hAAAA, 16'hF0CC);
      opr(ladder_pkg::OP_COPY_INV, 16'hF0CC, 16'hAAAA, 16'h0F33);
      opr(ladder_pkg::OP_INVERT, 16'h1234, 16'h0000, 16'hEDCB);
      opr(ladder_pkg::OP_AND, 16'hF0CC, 16'hAAAA, 16'hA088);
      opr(ladder_pkg::OP_OR, 16'hF0CC, 16'hAAAA, 16'hFAEE);
      opr(ladder_pkg::OP_XOR, 16'hF0CC, 16'hAAAA, 16'h5A66);
      opr(ladder_pkg::OP_XNOR, 16'hF0CC, 16'hAAAA, 16'hA599);
      $display("t_logic done");
   endtask

   task automatic t_bcd();
      opr(ladder_pkg::OP_BCD_TO_BIN, 16'h9999, 16'h0000, 16'h270F);
      opr(ladder_pkg::OP_BIN_TO_BCD, 16'h270F, 16'h0000, 16'h9999);
      cyop(ladder_pkg::OP_CARRY_CLR, 1'b0);
      opc(ladder_pkg::OP_BCD_SUB, 16'h0000, 16'h0001, 16'h9999, 1'b1);
      opc(ladder_pkg::OP_BCD_ADD, 16'h9999, 16'h0000, 16'h0000, 1'b1);
      opr(ladder_pkg::OP_BCD_MUL, 16'h9999, 16'h9999, 16'h0001);
      chk("high", 16'h9998, RES_HI);
      opr(ladder_pkg::OP_BCD_DIV, 16'h9999, 16'h0007, 16'h1428);
      chk("high", 16'h0003, RES_HI);
      opr(ladder_pkg::OP_BCD_ADD, 16'h00A0, 16'h0001, 16'h1428);
      chb("err", 1'b1, FLAGS.err);
      opr(ladder_pkg::OP_BCD_INC, 16'h9999, 16'h0000, 16'h0000);
      opr(ladder_pkg::OP_BCD_DEC, 16'h0000, 16'h0000, 16'h9999);
      cyop(ladder_pkg::OP_CARRY_SET, 1'b1);
      $display("t_bcd done");
   endtask

   task automatic t_shift();
      opc(ladder_pkg::OP_SHIFT_LEFT, 16'h8001, 16'h0000, 16'h0002, 1'b1);
      opc(ladder_pkg::OP_SHIFT_RIGHT, 16'h0002, 16'h0000, 16'h0001, 1'b0);
      opc(ladder_pkg::OP_ROT_LEFT, 16'h8000, 16'h0000, 16'h0000, 1'b1);
      opc(ladder_pkg::OP_ROT_RIGHT, 16'h0000, 16'h0000, 16'h8000, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         go(ladder_pkg::OP_COMPARE, 16'h0006, 16'(7 - i));
         chk("cmp", {13'h0000, 3'b001 << i}, {13'h0000, FLAGS.above, FLAGS.match, FLAGS.below});
      end
      $display("t_shift done");
   endtask

   task automatic t_edges();
      opr(ladder_pkg::OP_COPY, 16'h0055, 16'h0000, 16'h0055);
      ed(1'b0, 16'hAAAA, 16'h0055);
      ed(1'b1, 16'h1234, 16'h1234);
      ed(1'b1, 16'h5678, 16'h1234);
      pl(ladder_pkg::OP_RISE, 4'h1, 1'b0, 1'b0);
      pl(ladder_pkg::OP_RISE, 4'h1, 1'b1, 1'b1);
      pl(ladder_pkg::OP_RISE, 4'h1, 1'b1, 1'b0);
      pl(ladder_pkg::OP_FALL, 4'h2, 1'b1, 1'b0);
      pl(ladder_pkg::OP_FALL, 4'h2, 1'b0, 1'b1);
      pl(ladder_pkg::OP_FALL, 4'h2, 1'b0, 1'b0);
      $display("t_edges done");
   endtask

   task automatic t_count();
      ct(1'b1, 1'b0, 1'b0, 16'h0000);
      ct(1'b0, 1'b1, 1'b0, 16'h0001);
      ct(1'b0, 1'b1, 1'b0, 16'h0001);
      ct(1'b0, 1'b0, 1'b1, 16'h0000);
      ct(1'b0, 1'b0, 1'b0, 16'h0000);
      ct(1'b0, 1'b0, 1'b1, 16'h9999);
      $display("t_count done");
   endtask

   task automatic t_timer();
      int n;
      run(ladder_pkg::OP_FAST_TIMER, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0003, 16'h0000);
      chk("timer", 16'h0003, TIMER_PV);
      chb("timer_up", 1'b0, TIMER_UP);
      run(ladder_pkg::OP_FAST_TIMER, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0003, 16'h0000);
      for (n = 0; n < 40 && TIMER_UP !== 1'b1; n++)
      begin
         @(posedge CLK);
         #1;
      end
      chb("span", 1'b1, n >= 8 && n <= 16);
      chk("timer", 16'h0000, TIMER_PV);
      $display("t_timer done");
   endtask

   task automatic t_mem();
      wr(4'h2, 16'h1111);
      wr(4'h3, 16'h2222);
      wr(4'h4, 16'h3333);
      go(ladder_pkg::OP_WORD_SHIFT, 16'h0002, 16'h0004);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h1111);
      rd(4'h4, 16'h2222);
      go(ladder_pkg::OP_WORD_SHIFT, 16'h0004, 16'h0002);
      chb("err", 1'b1, FLAGS.err);
      rd(4'h4, 16'h2222);
      for (int i = 0; i < 8; i++)
      begin
         wr(4'(8 + i), {8'(8'h41 + 2 * i), 8'(8'h42 + 2 * i)});
      end
      k = 0;
      go(ladder_pkg::OP_MESSAGE, 16'h0008, 16'h0000);
      chk("chars", 16'h0010, 16'(k));
      $display("t_mem done");
   endtask

   // Back-to-back set then clear, one request per cycle
   task automatic t_order();
      @(posedge CLK);
      OP_VALID <= 1'b1;
      OP_REQ <= '{ladder_pkg::OP_CARRY_SET, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h0000};
      @(posedge CLK);
      OP_REQ.code <= ladder_pkg::OP_CARRY_CLR;
      #1;
      chb("carry", 1'b1, FLAGS.cy);
      @(posedge CLK);
      OP_VALID <= 1'b0;
      #1;
      chb("done", 1'b1, OP_DONE);
      chb("carry", 1'b0, FLAGS.cy);
      $display("t_order done");
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // The whole run needs well under a thousand cycles
   initial
   begin
      #100000;
      fails++;
      end_of_test();
   end

   initial
   begin
      NRST = 1'b0;
      OP_VALID = 1'b0;
      OP_REQ = '0;
      MEM_WE = 1'b0;
      MEM_ADDR = 4'h0;
      MEM_WDATA = 16'h0000;
      repeat (16) @(posedge CLK);
      NRST <= 1'b1;
      t_logic();
      t_bcd();
      t_shift();
      t_edges();
      t_count();
      t_timer();
      t_mem();
      t_order();
      end_of_test();
   end
endmodule
